// ### logic/frs_core.sv
// flag register instructions and string repeat control
// Overview of operation
// - step indexes by element, direction picks sign
// - set and clear direction instructions
// - plain repeat runs while count nonzero
// - repeat-equal needs count nonzero, zero set
// - repeat-not-equal needs count nonzero, zero clear
// - set, clear, complement carry
// - interrupt flag gates hardware interrupt input
// - flags copied into high byte bits
// - high byte bits loaded into flags
// - 16-bit push gives lower flag word
// - 32-bit push clears resume and v86
// - 16-bit pop updates fixed bit set
// - privilege zero pop also updates io field
// - pop updates interrupt flag when field >= level
// - 32-bit pop also updates alignment, identification
// - interrupt instructions gated by mode, level
`timescale 1ns/1ps
`default_nettype none
module frs_core
  import frs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        op_valid,
  input  wire frs_op_t     op_code,
  input  wire logic [31:0] op_data,
  input  wire logic [1:0]  current_privilege_level,
  input  wire logic        protected_mode,
  input  wire logic        virtual_mode,
  input  wire logic        status_valid,
  input  wire logic        zero_flag_in,
  input  wire logic [31:0] status_in,
  input  wire logic        str_start,
  input  wire frs_rep_t    str_prefix,
  input  wire logic [1:0]  str_elem,
  input  wire logic [31:0] source_index_in,
  input  wire logic [31:0] dest_index_in,
  input  wire logic [31:0] count_register_in,
  input  wire logic        str_iter_done,
  input  wire logic        hardware_interrupt_input,
  output logic [31:0]      processor_flags,
  output logic [7:0]       accumulator_high_byte,
  output logic             high_byte_valid,
  output logic [31:0]      push_data,
  output logic             push_valid,
  output logic             priv_fault,
  output logic [31:0]      source_index,
  output logic [31:0]      dest_index,
  output logic [31:0]      count_register,
  output logic             str_busy,
  output logic             str_iter_req,
  output logic             str_end,
  output logic             hardware_interrupt_input_take
);
  logic [31:0] flags_reg;
  logic [31:0] flags_next;
  logic [31:0] pop_mask;
  logic        int_ok;
  logic [31:0] step;
  logic [31:0] cnt_next;
  logic        keep_going;
  logic        run_reg;
  frs_rep_t    pfx_reg;
  logic [1:0]  elem_reg;

  function automatic logic [31:0] elem_bytes(input logic [1:0] e);
    case (e)
      ELEM_WORD:  elem_bytes = 32'h0000_0002;
      ELEM_DWORD: elem_bytes = 32'h0000_0004;
      default:    elem_bytes = 32'h0000_0001;
    endcase
  endfunction

  // does the prefix allow another iteration
  function automatic logic rep_more(input frs_rep_t p,
                                    input logic [31:0] c,
                                    input logic z);
    case (p)
      FRS_REP_ALL: rep_more = (c != 32'h0);
      FRS_REP_EQ:  rep_more = (c != 32'h0) && z;
      FRS_REP_NE:  rep_more = (c != 32'h0) && !z;
      default:     rep_more = 1'b0;
    endcase
  endfunction

  frs_pop_mask u_pop_mask (
    .is32     (op_code == FRS_OP_POP32),
    .cur_priv (current_privilege_level),
    .io_priv  (flags_reg[IO_PRIV_LO +: 2]),
    .mask     (pop_mask)
  );

  // interrupt instr permission
  // real mode always; v86 needs field at 3, protected field >= level
  assign int_ok = !protected_mode ||
    (virtual_mode ? (flags_reg[IO_PRIV_LO +: 2] == IO_PRIV_V86)
                  : (flags_reg[IO_PRIV_LO +: 2] >= current_privilege_level));

  always_comb begin
    flags_next = flags_reg;
    if (status_valid) begin
      flags_next = status_in;
    end
    if (op_valid) begin
      case (op_code)
        FRS_OP_SET_DIR:    flags_next[DIR_BIT] = 1'b1;
        FRS_OP_CLR_DIR:    flags_next[DIR_BIT] = 1'b0;
        FRS_OP_SET_CARRY:  flags_next[CARRY_BIT] = 1'b1;
        FRS_OP_CLR_CARRY:  flags_next[CARRY_BIT] = 1'b0;
        FRS_OP_FLIP_CARRY: flags_next[CARRY_BIT] = !flags_next[CARRY_BIT];
        FRS_OP_SET_INT: begin
          if (int_ok) begin
            flags_next[IF_BIT] = 1'b1;
          end
        end
        FRS_OP_CLR_INT: begin
          if (int_ok) begin
            flags_next[IF_BIT] = 1'b0;
          end
        end
        FRS_OP_BYTE_TO_FLAGS: begin
          flags_next[7:0] = (flags_next[7:0] & ~HB_MASK) |
                            (op_data[7:0] & HB_MASK);
        end
        FRS_OP_POP16, FRS_OP_POP32: begin
          flags_next = (flags_next & ~pop_mask) | (op_data & pop_mask);
        end
        // status or, with a status_valid load of status_in, the only ways to raise resume and v86
        FRS_OP_STATUS: flags_next = flags_next | op_data;
        default: flags_next = flags_next;
      endcase
    end
    flags_next = flags_next | FIXED_ONE;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      processor_flags <= FLAGS_RESET;
    end else begin
      processor_flags <= flags_next;
    end
  end

  // flags to byte, undefined bits read zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      accumulator_high_byte <= 8'h00;
      high_byte_valid       <= 1'b0;
    end else begin
      high_byte_valid <= op_valid && (op_code == FRS_OP_FLAGS_TO_BYTE);
      if (op_valid && (op_code == FRS_OP_FLAGS_TO_BYTE)) begin
        accumulator_high_byte <= flags_reg[7:0] & HB_MASK;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      push_data  <= 32'h0;
      push_valid <= 1'b0;
      priv_fault <= 1'b0;
    end else begin
      push_valid <= op_valid && ((op_code == FRS_OP_PUSH16) ||
                                 (op_code == FRS_OP_PUSH32));
      priv_fault <= op_valid && !int_ok &&
                    ((op_code == FRS_OP_SET_INT) ||
                     (op_code == FRS_OP_CLR_INT));
      if (op_valid && (op_code == FRS_OP_PUSH16)) begin
        push_data <= {16'h0, flags_reg[15:0]};
      end else if (op_valid && (op_code == FRS_OP_PUSH32)) begin
        push_data <= flags_reg & ~PUSH32_CLR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hardware_interrupt_input_take <= 1'b0;
    end else begin
      hardware_interrupt_input_take <= hardware_interrupt_input && flags_reg[IF_BIT];
    end
  end

  assign step = flags_reg[DIR_BIT] ? (32'h0 - elem_bytes(elem_reg))
                                  : elem_bytes(elem_reg);
  assign cnt_next = count_register - 32'h1;
  assign keep_going = (pfx_reg == FRS_REP_NONE) ? 1'b0 :
    rep_more(pfx_reg, cnt_next, flags_next[ZERO_BIT] |
             (zero_flag_in & status_valid));

  // a repeat with zero count does no iteration at all
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_reg        <= 1'b0;
      pfx_reg        <= FRS_REP_NONE;
      elem_reg       <= ELEM_BYTE;
      source_index   <= 32'h0;
      dest_index     <= 32'h0;
      count_register <= 32'h0;
      str_busy       <= 1'b0;
      str_iter_req   <= 1'b0;
      str_end        <= 1'b0;
    end else begin
      str_end <= 1'b0;
      if (str_start && !run_reg) begin
        pfx_reg        <= str_prefix;
        elem_reg       <= str_elem;
        source_index   <= source_index_in;
        dest_index     <= dest_index_in;
        count_register <= count_register_in;
        if ((str_prefix != FRS_REP_NONE) && (count_register_in == 32'h0)) begin
          str_end <= 1'b1;
        end else begin
          run_reg      <= 1'b1;
          str_busy     <= 1'b1;
          str_iter_req <= 1'b1;
        end
      end else if (run_reg && str_iter_done) begin
        source_index <= source_index + step;
        dest_index   <= dest_index + step;
        if (pfx_reg != FRS_REP_NONE) begin
          count_register <= cnt_next;
        end
        if (!keep_going) begin
          run_reg      <= 1'b0;
          str_busy     <= 1'b0;
          str_iter_req <= 1'b0;
          str_end      <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/frs_pkg.sv
// constants for the flag register and string repeat unit
package frs_pkg;
  localparam int unsigned FLAG_W = 32;
  localparam int unsigned CARRY_BIT     = 0;
  localparam int unsigned PARITY_BIT    = 2;
  localparam int unsigned AUX_CARRY_BIT = 4;
  localparam int unsigned ZERO_BIT      = 6;
  localparam int unsigned SIGN_BIT      = 7;
  localparam int unsigned IF_BIT        = 9;
  localparam int unsigned DIR_BIT       = 10;
  localparam int unsigned IO_PRIV_LO    = 12;
  localparam int unsigned RESUME_BIT    = 16;
  localparam int unsigned V86_BIT       = 17;
  localparam int unsigned ALIGN_CHK_BIT = 18;
  localparam int unsigned IDENT_BIT     = 21;
  // bit 1 of the flag register always reads as one
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  localparam logic [31:0] FIXED_ONE   = 32'h0000_0002;
  // byte image mask for the high-byte transfers
  localparam logic [7:0]  HB_MASK     = 8'hd5;
  localparam logic [31:0] POP16_MASK  = 32'h0000_0dd5;
  localparam logic [31:0] IO_PRIV_MASK = 32'h0000_3000;
  localparam logic [31:0] IF_MASK     = 32'h0000_0200;
  localparam logic [31:0] POP32_XTRA  = 32'h0024_0000;
  localparam logic [31:0] PUSH32_CLR  = 32'h0003_0000;
  localparam logic [1:0]  PRIV_TOP    = 2'h0;
  // v86 tasks may set or clear the interrupt flag by instruction only at this field value
  localparam logic [1:0]  IO_PRIV_V86 = 2'h3;
  localparam logic [1:0]  ELEM_BYTE   = 2'h0;
  localparam logic [1:0]  ELEM_WORD   = 2'h1;
  localparam logic [1:0]  ELEM_DWORD  = 2'h2;

  typedef enum logic [4:0] {
    FRS_OP_NONE, FRS_OP_SET_DIR, FRS_OP_CLR_DIR, FRS_OP_SET_CARRY,
    FRS_OP_CLR_CARRY, FRS_OP_FLIP_CARRY, FRS_OP_SET_INT, FRS_OP_CLR_INT,
    FRS_OP_FLAGS_TO_BYTE, FRS_OP_BYTE_TO_FLAGS,
    FRS_OP_PUSH16, FRS_OP_PUSH32, FRS_OP_POP16, FRS_OP_POP32,
    FRS_OP_STATUS
  } frs_op_t;

  typedef enum logic [1:0] {
    FRS_REP_NONE, FRS_REP_ALL, FRS_REP_EQ, FRS_REP_NE
  } frs_rep_t;
endpackage

// ### logic/frs_pop_mask.sv
// write mask for a flag pop
`timescale 1ns/1ps
`default_nettype none
module frs_pop_mask
  import frs_pkg::*;
(
  input  wire logic        is32,
  input  wire logic [1:0]  cur_priv,
  input  wire logic [1:0]  io_priv,
  output logic      [31:0] mask
);
  always_comb begin
    mask = POP16_MASK;
    if (cur_priv == PRIV_TOP) begin
      mask = mask | IO_PRIV_MASK;
    end
    if (io_priv >= cur_priv) begin
      mask = mask | IF_MASK;
    end
    if (is32) begin
      mask = mask | POP32_XTRA;
    end
  end
endmodule
`default_nettype wire

// ### sim/frs_core_properties.sv
// concurrent checks on the flag and string unit ports
`timescale 1ns/1ps
`default_nettype none
module frs_core_props
  import frs_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        op_valid,
  input wire frs_op_t     op_code,
  input wire logic [31:0] processor_flags,
  input wire logic [7:0]  accumulator_high_byte,
  input wire logic [31:0] push_data,
  input wire logic        hardware_interrupt_input,
  input wire logic        hardware_interrupt_input_take
);
  wire logic [31:0] flg = processor_flags;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  carry_set_a: assert property (
    op_valid && op_code == FRS_OP_SET_CARRY |=> flg[CARRY_BIT])
    else $error("carry not set");
  carry_clr_a: assert property (
    op_valid && op_code == FRS_OP_CLR_CARRY |=> !flg[CARRY_BIT])
    else $error("carry not cleared");
  carry_flip_a: assert property (
    op_valid && op_code == FRS_OP_FLIP_CARRY |=>
    flg[CARRY_BIT] != $past(flg[CARRY_BIT]))
    else $error("carry not inverted");
  dir_set_a: assert property (
    op_valid && op_code == FRS_OP_SET_DIR |=> flg[DIR_BIT])
    else $error("direction not set");
  dir_clr_a: assert property (
    op_valid && op_code == FRS_OP_CLR_DIR |=> !flg[DIR_BIT])
    else $error("direction not cleared");
  high_byte_a: assert property (
    op_valid && op_code == FRS_OP_FLAGS_TO_BYTE |=>
    accumulator_high_byte == ($past(flg[7:0]) & HB_MASK) && $stable(flg))
    else $error("high byte image wrong");
  push_low_a: assert property (
    op_valid && op_code == FRS_OP_PUSH16 |=>
    push_data == {16'h0, $past(flg[15:0])})
    else $error("narrow push image wrong");
  push_wide_a: assert property (
    op_valid && op_code == FRS_OP_PUSH32 |=>
    push_data == ($past(flg) & ~PUSH32_CLR))
    else $error("wide push image wrong");
  hardware_interrupt_input_gate_a: assert property (
    hardware_interrupt_input_take == $past(hardware_interrupt_input && flg[IF_BIT]))
    else $error("interrupt gating wrong");
endmodule
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the flag and string unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import frs_pkg::*;
  int          bad_count = 0, num_checks = 0, cyc = 0;
  logic        core_clk = 0, arst_n = 0, op_valid = 0, pmode = 0;
  logic        vmode = 0, st_v = 0, zin = 0, s_go = 0, s_done = 0, irq = 0;
  logic [1:0]  priv = 0, elem = 0;
  logic [31:0] op_data = 0, st_in = 0, si_in = 0, di_in = 0, n_in = 0;
  frs_op_t     op_code = FRS_OP_NONE;
  frs_rep_t    pfx = FRS_REP_NONE;
  logic [31:0] flg, push_data, si, di, cnt;
  logic [7:0]  ahb;
  logic        hbv, pv, fault, busy, ireq, s_end, itake;
  frs_op_t     cops[4] = '{FRS_OP_SET_CARRY, FRS_OP_CLR_CARRY,
                           FRS_OP_FLIP_CARRY, FRS_OP_FLIP_CARRY};
  logic [31:0] cexp[4] = '{32'h1, 32'h0, 32'h1, 32'h0};

  frs_core u_frs_core (.core_clk(core_clk), .arst_n(arst_n),
    .op_valid(op_valid), .op_code(op_code), .op_data(op_data),
    .current_privilege_level(priv), .protected_mode(pmode),
    .virtual_mode(vmode), .status_valid(st_v), .zero_flag_in(zin),
    .status_in(st_in), .str_start(s_go), .str_prefix(pfx),
    .str_elem(elem), .source_index_in(si_in), .dest_index_in(di_in),
    .count_register_in(n_in), .str_iter_done(s_done),
    .hardware_interrupt_input(irq), .processor_flags(flg),
    .accumulator_high_byte(ahb), .high_byte_valid(hbv),
    .push_data(push_data), .push_valid(pv), .priv_fault(fault),
    .source_index(si), .dest_index(di), .count_register(cnt),
    .str_busy(busy), .str_iter_req(ireq), .str_end(s_end),
    .hardware_interrupt_input_take(itake));

  always #50 core_clk = ~core_clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // hang guard, tests need about a hundred cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic op(frs_op_t c, logic [31:0] d = 32'h0);
    @(posedge core_clk);
    op_valid <= 1'h1;
    op_code <= c;
    op_data <= d;
    @(posedge core_clk);
    op_valid <= 1'h0;
    #1;
  endtask

  // done pulses alternate with idle cycles, zero flag fed with each
  task automatic run(frs_rep_t p, logic [1:0] e, logic [31:0] n, logic z,
                     logic [31:0] ix, logic [31:0] nx, logic [31:0] sx);
    logic [31:0] it;
    logic        go;
    it = 32'h0;
    @(posedge core_clk);
    s_go <= 1'h1;
    pfx <= p;
    elem <= e;
    n_in <= n;
    si_in <= 32'h100;
    di_in <= 32'h200;
    @(posedge core_clk);
    s_go <= 1'h0;
    repeat (24) begin
      @(posedge core_clk);
      if (s_end === 1'h1) break;
      go = ireq === 1'h1 && s_done !== 1'h1;
      s_done <= go;
      zin <= go && z;
      st_v <= go;
      st_in <= z ? (flg | 32'h40) : (flg & ~32'h40);
      if (go) it++;
    end
    chk(it, ix);
    chk({31'h0, busy}, 32'h0);
    chk(cnt, nx);
    chk(si, sx);
    chk(di, sx + 32'h100);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'h1;
    op(FRS_OP_PUSH16);
    chk(push_data & 32'hffff, 32'h2);
    chk({31'h0, pv}, 32'h1);
    foreach (cops[i]) begin
      op(cops[i]);
      chk(flg & 32'h1, cexp[i]);
    end
    op(FRS_OP_BYTE_TO_FLAGS, 32'hff);
    chk(flg & 32'hff, 32'hd7);
    op(FRS_OP_FLAGS_TO_BYTE);
    chk({24'h0, ahb}, 32'hd5);
    chk({31'h0, hbv}, 32'h1);
    run(FRS_REP_ALL, ELEM_BYTE, 32'h3, 1'h0, 32'h3, 32'h0, 32'h103);
    run(FRS_REP_EQ, ELEM_DWORD, 32'h5, 1'h0, 32'h1, 32'h4, 32'h104);
    run(FRS_REP_EQ, ELEM_WORD, 32'h2, 1'h1, 32'h2, 32'h0, 32'h104);
    run(FRS_REP_NE, ELEM_BYTE, 32'h4, 1'h1, 32'h1, 32'h3, 32'h101);
    run(FRS_REP_ALL, ELEM_BYTE, 32'h0, 1'h0, 32'h0, 32'h0, 32'h100);
    op(FRS_OP_SET_DIR);
    chk(flg & 32'h400, 32'h400);
    run(FRS_REP_NE, ELEM_WORD, 32'h2, 1'h0, 32'h2, 32'h0, 32'hfc);
    run(FRS_REP_NONE, ELEM_DWORD, 32'h7, 1'h0, 32'h1, 32'h7, 32'hfc);
    op(FRS_OP_CLR_DIR);
    chk(flg & 32'h400, 32'h0);
    @(posedge core_clk) priv <= 2'h3;
    op(FRS_OP_POP16, 32'hffff_ffff);
    chk(flg, 32'h0000_0dd7);
    @(posedge core_clk) priv <= 2'h0;
    op(FRS_OP_POP32, 32'hffff_ffff);
    chk(flg, 32'h0024_3fd7);
    op(FRS_OP_STATUS, 32'h0003_0000);
    op(FRS_OP_PUSH32);
    chk(push_data, 32'h0024_3fd7);
    op(FRS_OP_POP16, 32'h0000_0200);
    chk(flg, 32'h0027_0202);
    @(posedge core_clk) irq <= 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    chk({31'h0, itake}, 32'h1);
    @(posedge core_clk) priv <= 2'h3;
    @(posedge core_clk) pmode <= 1'h1;
    op(FRS_OP_CLR_INT);
    chk({31'h0, fault}, 32'h1);
    chk(flg & 32'h200, 32'h200);
    op(FRS_OP_POP16, 32'h0);
    chk(flg, 32'h0027_0202);
    @(posedge core_clk) priv <= 2'h0;
    op(FRS_OP_CLR_INT);
    chk({31'h0, fault}, 32'h0);
    chk(flg & 32'h200, 32'h0);
    op(FRS_OP_SET_INT);
    chk(flg & 32'h200, 32'h200);
    @(posedge core_clk) vmode <= 1'h1;
    op(FRS_OP_CLR_INT);
    chk({31'h0, fault}, 32'h1);
    chk(flg & 32'h200, 32'h200);
    op(FRS_OP_POP16, 32'h0000_3200);
    chk(flg, 32'h0027_3202);
    op(FRS_OP_CLR_INT);
    chk({31'h0, fault}, 32'h0);
    chk(flg & 32'h200, 32'h0);
    tally_and_finish();
  end
endmodule

bind frs_core frs_core_props u_frs_core_props (.core_clk(core_clk),
  .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
  .processor_flags(processor_flags),
  .accumulator_high_byte(accumulator_high_byte), .push_data(push_data),
  .hardware_interrupt_input(hardware_interrupt_input),
  .hardware_interrupt_input_take(hardware_interrupt_input_take));
`default_nettype wire
